// ---- common/eeu_pkg.sv ----
// Constants and types of the exception entry unit
package eeu_pkg;
  localparam logic [31:0] RESET_PC = 32'hA0000000;
  localparam logic [31:0] VBR_RESET = 32'h00000000;
  localparam logic [31:0] VEC_GEN = 32'h00000100;
  localparam logic [31:0] VEC_MISS = 32'h00000400;
  localparam logic [31:0] VEC_INT = 32'h00000600;
  localparam logic [31:0] USER_LIMIT = 32'h80000000;
  localparam logic [31:0] SR_RESET = 32'h700000F0;
  localparam logic [31:0] SR_ENTER = 32'h70000000;
  localparam int SR_MD = 30;
  localparam int SR_BL = 28;
  localparam int SR_IM_LO = 4;
  localparam int VPN_LO = 10;
  localparam logic [11:0] EC_POR = 12'h000;
  localparam logic [11:0] EC_MAN = 12'h020;
  localparam logic [11:0] EC_MISS_RD = 12'h040;
  localparam logic [11:0] EC_MISS_WR = 12'h060;
  localparam logic [11:0] EC_IPW = 12'h080;
  localparam logic [11:0] EC_PROT_RD = 12'h0A0;
  localparam logic [11:0] EC_PROT_WR = 12'h0C0;
  localparam logic [11:0] EC_AE_RD = 12'h0E0;
  localparam logic [11:0] EC_AE_WR = 12'h100;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_VBASE = 8'h04;
  localparam logic [7:0] OFS_SPC = 8'h08;
  localparam logic [7:0] OFS_SSTAT = 8'h0C;
  localparam logic [7:0] OFS_EXC = 8'h10;
  localparam logic [7:0] OFS_INT = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_PAGE_ENTRY_HIGH = 8'h1C;
  localparam logic [7:0] OFS_XLAT = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] SZ_WORD = 2'b01;
  localparam logic [1:0] SZ_LONG = 2'b10;
  typedef enum logic [1:0] {ST_RUN = 2'b01, ST_RST = 2'b10} eeu_st_t;
  typedef struct packed {
    logic valid; logic fetch; logic write; logic [1:0] size;
    logic [31:0] addr; logic [31:0] pc;
  } eeu_acc_t;
  typedef struct packed {
    logic hit; logic valid; logic dirty; logic [1:0] prot; logic [1:0] way;
  } eeu_tlb_t;
endpackage

// ---- rtl/eeu_exception_entry.sv ----
// Exception entry unit: reset, interrupt and general exception entry with AXI4-Lite registers
// Function
// - sample reset pin; power-on halts, cancels all
// - manual reset keeps memory retention running
// - reset-kind input selects power-on or manual
// - reset sets flags, mask all ones, base zero
// - reset code 000 power-on, 020 manual
// - after reset fetch from A0000000
// - interrupts taken only at instruction boundary
// - interrupt saves state, codes, jumps base+600
// - exception saves state, sets flags, writes code
// - miss vectors base+400, others base+100
// - translation miss codes 040 read, 060 write
// - miss records address, page, increments counter
// - invalid entry records address, page, way
// - store to clean page raises code 080
// - two-bit protection field checks mode access
// - protection violation codes 0A0 and 0C0
// - misaligned fetch, word, longword raise address error
// - user access at or above 80000000 errs
// - address error records address, codes 0E0/100
// - block flag holds interrupts pending
// - exception under block flag restarts at A0000000 with reset status and base
module eeu_exception_entry
  import eeu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reset_pin_n,
  input wire logic reset_kind_input,
  input wire logic boundary,
  input wire logic [31:0] next_pc,
  input wire logic irq_req,
  input wire logic [3:0] irq_level,
  input wire logic [11:0] irq_code,
  input wire eeu_acc_t acc,
  input wire eeu_tlb_t tlb,
  output logic redirect_valid,
  output logic [31:0] redirect_addr,
  output logic core_halt,
  output logic cancel_pending,
  output logic keep_retention,
  output logic irq_ack,
  output logic exc_ack,
  output logic [31:0] proc_status_word
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    eeu_st_t st;
    logic [31:0] sr;
    logic [31:0] vector_base;
    logic [31:0] saved_pc;
    logic [31:0] saved_status;
    logic [11:0] exception_event_code;
    logic [11:0] interrupt_event_code;
    logic [31:0] fault_address;
    logic [31:0] page_entry_high;
    logic [1:0] rc;
    logic redir_v;
    logic [31:0] redir_a;
    logic halt;
    logic cancel;
    logic retain;
    logic iack;
    logic eack;
    logic awrdy;
    logic wrdy;
    logic [7:0] wadr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bv;
    logic [1:0] br;
    logic arrdy;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } eeu_state_t;

  eeu_state_t q;
  eeu_state_t d;
  logic rst_n;
  logic por;
  logic user;
  logic misal;
  logic ae;
  logic miss;
  logic inv;
  logic pv;
  logic ipw;
  logic exc;
  logic take_irq;
  logic [11:0] code;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a <= OFS_XLAT && a[1:0] == 2'b00;
  endfunction

  // Protection: bit0 grants write, bit1 grants user access
  function automatic logic prot_bad(input logic [1:0] pr, input logic u, input logic w);
    return (u && !pr[1]) || (w && !pr[0]);
  endfunction

  assign rst_n = q.s2[1];
  assign por = q.s2[0];
  assign user = !q.sr[SR_MD];

  always_comb
  begin
    // Misalignment by access kind; a fetch counts as a word
    if (acc.fetch || acc.size == SZ_WORD)
      misal = acc.addr[0];
    else if (acc.size == SZ_LONG)
      misal = |acc.addr[1:0];
    else
      misal = 1'b0;
    ae = misal || (user && acc.addr >= USER_LIMIT);
    miss = !ae && !tlb.hit;
    inv = !ae && tlb.hit && !tlb.valid;
    pv = !ae && tlb.hit && tlb.valid && prot_bad(tlb.prot, user, acc.write);
    ipw = !ae && tlb.hit && tlb.valid && !pv && acc.write && !tlb.dirty;
    exc = acc.valid && (ae || miss || inv || pv || ipw);
    // Priority: address error, then miss/invalid, protection, first write
    if (ae)
      code = acc.write ? EC_AE_WR : EC_AE_RD;
    else if (miss || inv)
      code = acc.write ? EC_MISS_WR : EC_MISS_RD;
    else if (pv)
      code = acc.write ? EC_PROT_WR : EC_PROT_RD;
    else
      code = EC_IPW;
    take_irq = boundary && irq_req && !q.sr[SR_BL]
               && irq_level > q.sr[SR_IM_LO +: 4];
  end

  always_comb
  begin
    d = q;
    d.s1 = {reset_pin_n, reset_kind_input};
    d.s2 = q.s1;
    d.redir_v = 1'b0;
    d.iack = 1'b0;
    d.eack = 1'b0;
    // Bus side; hardware events below override a same-cycle software write
    if (awvalid && q.awrdy)
    begin
      d.wadr = awaddr;
      d.awrdy = 1'b0;
    end
    if (wvalid && q.wrdy)
    begin
      d.wdat = wdata;
      d.wstb = wstrb;
      d.wrdy = 1'b0;
    end
    if (!q.awrdy && !q.wrdy && !q.bv)
    begin
      d.bv = 1'b1;
      d.br = mapped(q.wadr) ? RESP_OKAY : RESP_SLVERR;
      unique case (q.wadr)
        OFS_STATUS: d.sr = merge(q.sr, q.wdat, q.wstb);
        OFS_VBASE: d.vector_base = merge(q.vector_base, q.wdat, q.wstb);
        OFS_SPC: d.saved_pc = merge(q.saved_pc, q.wdat, q.wstb);
        OFS_SSTAT: d.saved_status = merge(q.saved_status, q.wdat, q.wstb);
        OFS_EXC: d.exception_event_code = 12'(merge({20'h0, q.exception_event_code}, q.wdat, q.wstb));
        OFS_INT: d.interrupt_event_code = 12'(merge({20'h0, q.interrupt_event_code}, q.wdat, q.wstb));
        OFS_FAULT: d.fault_address = merge(q.fault_address, q.wdat, q.wstb);
        OFS_PAGE_ENTRY_HIGH: d.page_entry_high = merge(q.page_entry_high, q.wdat, q.wstb);
        OFS_XLAT: d.rc = 2'(merge({30'h0, q.rc}, q.wdat, q.wstb));
        default: d.br = RESP_SLVERR;
      endcase
    end
    if (q.bv && bready)
    begin
      d.bv = 1'b0;
      d.awrdy = 1'b1;
      d.wrdy = 1'b1;
    end
    if (arvalid && q.arrdy)
    begin
      d.arrdy = 1'b0;
      d.rv = 1'b1;
      d.rr = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        OFS_STATUS: d.rd = q.sr;
        OFS_VBASE: d.rd = q.vector_base;
        OFS_SPC: d.rd = q.saved_pc;
        OFS_SSTAT: d.rd = q.saved_status;
        OFS_EXC: d.rd = {20'h0, q.exception_event_code};
        OFS_INT: d.rd = {20'h0, q.interrupt_event_code};
        OFS_FAULT: d.rd = q.fault_address;
        OFS_PAGE_ENTRY_HIGH: d.rd = q.page_entry_high;
        OFS_XLAT: d.rd = {30'h0, q.rc};
        default: d.rd = 32'h0;
      endcase
    end
    if (q.rv && rready)
    begin
      d.rv = 1'b0;
      d.arrdy = 1'b1;
    end
    // Reset pin first, so nothing else enters in the same cycle
    if (!rst_n)
    begin
      d.st = ST_RST;
      d.sr = SR_RESET;
      d.vector_base = VBR_RESET;
      d.exception_event_code = por ? EC_POR : EC_MAN;
      d.halt = 1'b1;
      d.cancel = por;
      d.retain = !por;
    end
    else if (q.st == ST_RST)
    begin
      d.st = ST_RUN;
      d.halt = 1'b0;
      d.cancel = 1'b0;
      d.retain = 1'b0;
      d.redir_v = 1'b1;
      d.redir_a = RESET_PC;
    end
    else if (exc && q.sr[SR_BL])
    begin
      // Nested fault: core state as at reset, other registers kept
      d.sr = SR_RESET;
      d.vector_base = VBR_RESET;
      d.redir_v = 1'b1;
      d.redir_a = RESET_PC;
      d.eack = 1'b1;
    end
    else if (exc)
    begin
      d.saved_pc = acc.pc;
      d.saved_status = q.sr;
      d.sr = q.sr | SR_ENTER;
      d.exception_event_code = code;
      d.fault_address = acc.addr;
      if (!ae)
      begin
        d.page_entry_high[31:VPN_LO] = acc.addr[31:VPN_LO];
        d.rc = miss ? q.rc + 2'd1 : tlb.way;
      end
      d.redir_v = 1'b1;
      d.redir_a = q.vector_base + (miss ? VEC_MISS : VEC_GEN);
      d.eack = 1'b1;
    end
    else if (take_irq)
    begin
      d.saved_pc = next_pc;
      d.saved_status = q.sr;
      d.sr = q.sr | SR_ENTER;
      d.interrupt_event_code = irq_code;
      d.redir_v = 1'b1;
      d.redir_a = q.vector_base + VEC_INT;
      d.iack = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.s1 <= 2'b11;
      q.s2 <= 2'b11;
      q.st <= ST_RUN;
      q.sr <= SR_RESET;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
    end
    else
      q <= d;
  end

  assign awready = q.awrdy;
  assign wready = q.wrdy;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = q.arrdy;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign redirect_valid = q.redir_v;
  assign redirect_addr = q.redir_a;
  assign core_halt = q.halt;
  assign cancel_pending = q.cancel;
  assign keep_retention = q.retain;
  assign irq_ack = q.iack;
  assign exc_ack = q.eack;
  assign proc_status_word = q.sr;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_in_reset;
    !rst_n [*2];
  endsequence
  sequence s_released;
    rst_n;
  endsequence

  property p_por;
    !rst_n && por |=> core_halt && cancel_pending && !keep_retention;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset not halting");

  property p_man;
    !rst_n && !por |=> core_halt && keep_retention && !cancel_pending;
  endproperty
  a_man: assert property (p_man) else $error("manual reset stopped retention");

  property p_code;
    !rst_n |=> q.exception_event_code == (($past(por)) ? EC_POR : EC_MAN);
  endproperty
  a_code: assert property (p_code) else $error("wrong reset code");

  property p_reset_state;
    s_in_reset |-> proc_status_word == SR_RESET && q.vector_base == VBR_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_restart;
    s_in_reset ##1 s_released |=> redirect_valid && redirect_addr == RESET_PC;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart fetch");

  property p_irq;
    rst_n && q.st == ST_RUN && !exc && take_irq |=> irq_ack && q.sr[SR_BL]
      && redirect_addr == $past(q.vector_base) + VEC_INT && q.saved_pc == $past(next_pc);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt entry wrong");

  property p_blocked;
    q.sr[SR_BL] || !boundary |=> !irq_ack;
  endproperty
  a_blocked: assert property (p_blocked) else $error("interrupt taken while blocked");

  property p_miss;
    rst_n && q.st == ST_RUN && exc && miss && !q.sr[SR_BL] |=> exc_ack
      && redirect_addr == $past(q.vector_base) + VEC_MISS && q.rc == $past(q.rc) + 2'd1
      && q.fault_address == $past(acc.addr);
  endproperty
  a_miss: assert property (p_miss) else $error("miss entry wrong");

  property p_nested;
    rst_n && q.st == ST_RUN && exc && q.sr[SR_BL] |=> redirect_addr == RESET_PC
      && proc_status_word == SR_RESET;
  endproperty
  a_nested: assert property (p_nested) else $error("nested fault not reset");

  property p_ae;
    rst_n && q.st == ST_RUN && acc.valid && acc.fetch && acc.addr[0] && !q.sr[SR_BL]
      |=> q.exception_event_code == EC_AE_RD;
  endproperty
  a_ae: assert property (p_ae) else $error("odd fetch not an address error");

  property p_reset_wins;
    !rst_n |=> !irq_ack && !exc_ack && !redirect_valid;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("event during reset");
endmodule

// ---- sim/eeu_pipe_model.sv ----
// Pipeline-side model: presents accesses and holds interrupt requests
module eeu_pipe_model
  import eeu_pkg::*;
(
  input wire logic aclk,
  input wire logic fire,
  input wire eeu_acc_t acc_in,
  input wire eeu_tlb_t tlb_in,
  input wire logic irq_on,
  input wire logic irq_ack,
  output eeu_acc_t acc,
  output eeu_tlb_t tlb,
  output logic boundary,
  output logic irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  eeu_acc_t idle;
  initial
  begin
    acc = '0;
    tlb = '0;
    boundary = 1'b0;
    irq_req = 1'b0;
  end
  // Released bus shows inverted junk so a stale access cannot pass
  always_comb
  begin
    idle = ~acc;
    idle.valid = 1'b0;
  end
  always @(posedge aclk)
  begin
    acc <= fire ? acc_in : idle;
    tlb <= fire ? tlb_in : ~tlb;
    boundary <= ~boundary; // Instruction ends every other cycle
    irq_req <= irq_ack ? 1'b0 : (irq_req | irq_on); // Held until taken
  end
endmodule

// ---- sim/eeu_exception_entry_tb.sv ----
// Self-checking testbench of the exception entry unit
module eeu_exception_entry_tb
  import eeu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, redirect_valid, core_halt, cancel_pending;
  logic keep_retention, irq_ack, exc_ack, reset_pin_n, reset_kind_input;
  logic boundary, irq_req, fire, irq_on;
  logic [1:0] bresp, rresp, rr, rcv, wb;
  logic [3:0] wstrb, irq_level;
  logic [7:0] awaddr, araddr;
  logic [11:0] irq_code;
  logic [31:0] wdata, rdata, redirect_addr, proc_status_word, next_pc, vb, r, fa, d;
  eeu_acc_t acc, acc_in, a;
  eeu_tlb_t tlb, tlb_in, t;
  int fail_count = 0;
  int checks_done = 0;
  int n_exc = 0;
  int n_irq = 0;
  int n_red = 0;
  int k, ne, nr;
  eeu_exception_entry dut (.*);
  eeu_pipe_model pipe (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    n_exc <= n_exc + int'(exc_ack === 1'b1);
    n_irq <= n_irq + int'(irq_ack === 1'b1);
    n_red <= n_red + int'(redirect_valid === 1'b1);
  end
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", w, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        wb = bresp;
        bready <= 1'b0;
      end
    end
    while (bready);
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end
    while (rready);
  endtask
  task automatic rc(input logic [7:0] ad, input string w, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    rd(ad);
    chk(w, d & m, e);
  endtask
  task automatic hit(input eeu_acc_t ac, input eeu_tlb_t tl);
    @(posedge aclk);
    acc_in <= ac;
    tlb_in <= tl;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  function automatic logic [31:0] ecode(input int c);
    case (c)
      0, 2: return {20'h0, EC_MISS_RD};
      1: return {20'h0, EC_MISS_WR};
      3: return {20'h0, EC_IPW};
      4: return {20'h0, EC_PROT_RD};
      5: return {20'h0, EC_PROT_WR};
      7: return {20'h0, EC_AE_WR};
      default: return {20'h0, EC_AE_RD};
    endcase
  endfunction
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, irq_on} = '0;
    {awaddr, araddr, wdata, next_pc, irq_code, irq_level, acc_in, tlb_in} = '0;
    reset_pin_n = 1'b1;
    reset_kind_input = 1'b1;
    wstrb = 4'hF;
    rcv = 2'h0;
    void'($urandom(57));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk("status", proc_status_word, SR_RESET);
    rc(OFS_VBASE, "vbase", 32'h0);
    vb = $urandom & 32'h7FFFF000;
    wr(OFS_VBASE, vb);
    chk("write resp", {30'h0, wb}, {30'h0, RESP_OKAY});
    ne = n_exc;
    // Fault kinds: miss rd/wr, invalid, first write, protection, address errors
    for (k = 0; k < 9; k++)
    begin
      r = $urandom;
      a = '{valid: 1'b1, fetch: k == 8, write: k[0], size: k == 8 ? SZ_WORD : SZ_LONG,
            addr: {k == 7, r[30:2], 2'b00}, pc: $urandom};
      a.addr[1] = (k == 6);
      a.addr[0] = (k == 8);
      t = '{hit: k > 1, valid: k != 2, dirty: k != 3, way: r[1:0],
            prot: k == 4 ? 2'b00 : k == 5 ? 2'b10 : 2'b11};
      if (k < 2) rcv = rcv + 2'h1;
      else if (k < 6) rcv = t.way;
      wr(OFS_STATUS, 32'h0);
      hit(a, t);
      chk("entered", n_exc, ne + 1);
      ne = n_exc;
      chk("target", redirect_addr, vb + (k < 2 ? VEC_MISS : VEC_GEN));
      chk("status", proc_status_word, SR_ENTER);
      rc(OFS_EXC, "code", ecode(k));
      rc(OFS_FAULT, "fault", a.addr);
      rc(OFS_SPC, "saved pc", a.pc);
      rc(OFS_SSTAT, "saved status", 32'h0);
      if (k < 6) rc(OFS_PAGE_ENTRY_HIGH, "page", a.addr & 32'hFFFFFC00, 32'hFFFFFC00);
      rc(OFS_XLAT, "replace", {30'h0, rcv}, 32'h3);
    end
    fa = a.addr;
    a.addr = a.addr ^ 32'h10;
    hit(a, t);
    ne = n_exc;
    chk("target", redirect_addr, RESET_PC);
    chk("status", proc_status_word, SR_RESET);
    rc(OFS_VBASE, "vbase", 32'h0);
    rc(OFS_FAULT, "fault kept", fa);
    wr(OFS_VBASE, vb);
    wr(OFS_STATUS, 32'h70000030);
    irq_level <= 4'h4;
    irq_code <= r[11:0];
    next_pc <= r;
    irq_on <= 1'b1;
    @(posedge aclk);
    irq_on <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("held", n_irq, 0);
    wr(OFS_STATUS, 32'h30);
    repeat (4) @(posedge aclk);
    chk("taken", n_irq, 1);
    chk("target", redirect_addr, vb + VEC_INT);
    chk("status", proc_status_word, 32'h70000030);
    rc(OFS_INT, "int code", {20'h0, r[11:0]});
    rc(OFS_SPC, "saved pc", r);
    rc(OFS_SSTAT, "saved status", 32'h30);
    for (k = 1; k >= 0; k--)
    begin
      wr(OFS_VBASE, vb);
      reset_kind_input <= k[0]; // Kind held while the pin is low
      reset_pin_n <= 1'b0;
      repeat (4) @(posedge aclk);
      hit(a, t);
      chk("dropped", n_exc, ne);
      chk("halt", core_halt, 1'b1);
      chk("cancel", cancel_pending, k[0]);
      chk("retain", keep_retention, !k[0]);
      chk("status", proc_status_word, SR_RESET);
      rc(OFS_EXC, "code", k ? {20'h0, EC_POR} : {20'h0, EC_MAN});
      rc(OFS_VBASE, "vbase", 32'h0);
      nr = n_red;
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("restart pulse", n_red, nr + 1);
      chk("target", redirect_addr, RESET_PC);
      chk("halt", core_halt, 1'b0);
    end
    rd(8'h40);
    chk("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    wr(8'h40, $urandom);
    chk("unmapped wresp", {30'h0, wb}, {30'h0, RESP_SLVERR});
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
endmodule
